// ---- core/ext_memory_bus_interface.sv ----
/*
 * External memory and I/O bus interface: space selects, strobes, direction,
 * software and ready wait states, wait-state-done output, hold/release and
 * reset-time ROM map mode. Assumes the core issues one request at a time and
 * that pins (ready, hold, mode select, float control) are asynchronous.
 */
`default_nettype none
module ext_memory_bus_interface #(
	parameter logic [ext_bus_pkg::WS_W-1:0] WAIT_STATES = 3'h2
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic rom_map_mode_sel,
	input wire logic mode_override_valid,
	input wire logic mode_override,
	input wire logic req_valid,
	output logic req_ready,
	input wire ext_bus_pkg::bus_req_t req,
	output logic rsp_valid,
	output logic [ext_bus_pkg::DATA_W-1:0] rsp_rdata,
	output logic rsp_internal_rom,
	output logic processor_mode_status,
	input wire logic ready_pin,
	input wire logic hold_req_n,
	input wire logic emu_float_ctrl_n,
	output logic [ext_bus_pkg::ADDR_W-1:0] addr_o,
	output logic addr_oe,
	input wire logic [ext_bus_pkg::DATA_W-1:0] data_i,
	output logic [ext_bus_pkg::DATA_W-1:0] data_o,
	output logic data_oe,
	output logic data_space_sel_n,
	output logic program_space_sel_n,
	output logic io_space_sel_n,
	output logic mem_strobe_n,
	output logic io_strobe_n,
	output logic rw_n,
	output logic instr_fetch_addr_n,
	output logic bus_release_ack_n,
	output logic wait_states_done_n,
	output logic ctl_oe
);
	// Counter is WS_W bits wide, so larger wait counts cannot be served
	if (WAIT_STATES > 3'h7) begin : g_ws_range
		$error("WAIT_STATES out of range");
	end

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_READY = 2'b10,
		ST_HOLD = 2'b11
	} state_t;

	state_t state_r, state_nxt;
	logic [ext_bus_pkg::WS_W-1:0] ws_cnt_r, ws_cnt_nxt;
	ext_bus_pkg::bus_req_t cur_r;
	ext_bus_pkg::bus_ctl_t ctl_r, ctl_nxt;
	logic mc_mode_r;
	logic boot_pend_r;
	logic in_reset_r;
	logic [2:0] sync1_r, sync2_r;
	logic rsp_valid_r;
	logic [ext_bus_pkg::DATA_W-1:0] rdata_r;
	logic rom_hit_r;
	logic [1:0] mode_sync_r;

	// Two-flop synchronisers for ready, hold and float control
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_r <= 3'h6;
			sync2_r <= 3'h6;
		end else if (clk_en) begin
			sync1_r <= {hold_req_n, emu_float_ctrl_n, ready_pin};
			sync2_r <= sync1_r;
		end
	end

	wire ready_s = sync2_r[0];
	wire float_n_s = sync2_r[1];
	wire hold_s = ~sync2_r[2];

	// Mode select caught while reset is asserted, then software may override
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			in_reset_r <= 1'b1;
		end else if (clk_en) begin
			in_reset_r <= 1'b0;
		end
	end

	// Mode pin is static in reset but still asynchronous; two flops like the rest
	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			mode_sync_r <= {mode_sync_r[0], rom_map_mode_sel};
		end
	end

	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			if (in_reset_r) begin
				mc_mode_r <= ~mode_sync_r[1];
			end else if (mode_override_valid) begin
				mc_mode_r <= ~mode_override;
			end
		end
	end

	assign processor_mode_status = ~mc_mode_r;

	wire [ext_bus_pkg::ADDR_W-1:0] eff_addr =
		boot_pend_r ? ext_bus_pkg::RESET_FETCH_ADDR : req.addr;
	wire is_prog = boot_pend_r || (req.space == ext_bus_pkg::SPACE_PROG);
	wire rom_hit = mc_mode_r && is_prog &&
		(eff_addr[ext_bus_pkg::LOW_ADDR_W-1:0] >= ext_bus_pkg::ROM_BASE);
	wire take = (state_r == ST_IDLE) && req_valid && !hold_s && !in_reset_r;
	wire ext_take = take && !rom_hit;
	// Ready is sampled after the counted waits only if WAIT_STATES is at least READY_MIN_WS
	wire ready_gate = (WAIT_STATES >= ext_bus_pkg::READY_MIN_WS);
	wire ws_last = (ws_cnt_r == ext_bus_pkg::WS_ONE);

	assign req_ready = (state_r == ST_IDLE) && !hold_s && !in_reset_r;

	// Control pattern for a new external cycle; one select only
	ext_bus_pkg::bus_ctl_t ctl_new;
	always_comb begin
		ctl_new = ext_bus_pkg::CTL_IDLE;
		if (is_prog) begin
			ctl_new.prog_sel_n = 1'b0;
			ctl_new.mem_strobe_n = 1'b0;
		end else if (req.space == ext_bus_pkg::SPACE_DATA) begin
			ctl_new.data_sel_n = 1'b0;
			ctl_new.mem_strobe_n = 1'b0;
		end else begin
			ctl_new.io_sel_n = 1'b0;
			ctl_new.io_strobe_n = 1'b0;
		end
		ctl_new.rw = boot_pend_r || !req.write;
		ctl_new.fetch_n = !(boot_pend_r || req.fetch);
	end

	wire cycle_end = ((state_r == ST_WAIT) && ws_last && !ready_gate) ||
		((state_r == ST_WAIT) && (WAIT_STATES == 3'h0)) ||
		((state_r == ST_READY) && ready_s);

	always_comb begin
		state_nxt = state_r;
		ws_cnt_nxt = ws_cnt_r;
		ctl_nxt = ctl_r;
		unique case (state_r)
			ST_IDLE: begin
				if (hold_s) begin
					state_nxt = ST_HOLD;
				end else if (ext_take) begin
					state_nxt = ST_WAIT;
					ws_cnt_nxt = WAIT_STATES;
					ctl_nxt = ctl_new;
				end
			end
			ST_WAIT: begin
				if (cycle_end) begin
					state_nxt = ST_IDLE;
					ctl_nxt = ext_bus_pkg::CTL_IDLE;
				end else if (ws_last) begin
					state_nxt = ST_READY;
				end else begin
					ws_cnt_nxt = ws_cnt_r - ext_bus_pkg::WS_ONE;
				end
			end
			ST_READY: begin
				if (cycle_end) begin
					state_nxt = ST_IDLE;
					ctl_nxt = ext_bus_pkg::CTL_IDLE;
				end
			end
			ST_HOLD: begin
				if (!hold_s) state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			ws_cnt_r <= '0;
			ctl_r <= ext_bus_pkg::CTL_IDLE;
			boot_pend_r <= 1'b1;
		end else if (clk_en) begin
			state_r <= state_nxt;
			ws_cnt_r <= ws_cnt_nxt;
			ctl_r <= ctl_nxt;
			if (take) boot_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cur_r <= '0;
			rsp_valid_r <= 1'b0;
			rdata_r <= '0;
			rom_hit_r <= 1'b0;
		end else if (clk_en) begin
			if (take) begin
				cur_r <= req;
				cur_r.addr <= eff_addr;
				cur_r.write <= req.write && !boot_pend_r;
				if (boot_pend_r) cur_r.space <= ext_bus_pkg::SPACE_PROG;
			end
			rsp_valid_r <= (take && rom_hit) || cycle_end;
			rom_hit_r <= take && rom_hit;
			if (cycle_end) rdata_r <= data_i;
		end
	end

	assign rsp_valid = rsp_valid_r;
	assign rsp_rdata = rdata_r;
	assign rsp_internal_rom = rom_hit_r;

	wire busy = (state_r == ST_WAIT) || (state_r == ST_READY);
	// Hold waits for the cycle in flight to finish first
	wire hold_st = (state_r == ST_HOLD);

	// Upper four lines forced low outside program space
	wire [ext_bus_pkg::ADDR_W-1:0] addr_mux = {
		(cur_r.space == ext_bus_pkg::SPACE_PROG) ?
			cur_r.addr[ext_bus_pkg::ADDR_W-1:ext_bus_pkg::LOW_ADDR_W] : 4'h0,
		cur_r.addr[ext_bus_pkg::LOW_ADDR_W-1:0]};

	assign addr_o = addr_mux;
	assign addr_oe = !hold_st && float_n_s;
	assign data_o = cur_r.wdata;
	assign data_oe = busy && cur_r.write && !hold_st && float_n_s && !rst;
	assign ctl_oe = float_n_s && !hold_st;
	assign data_space_sel_n = ctl_r.data_sel_n;
	assign program_space_sel_n = ctl_r.prog_sel_n;
	assign io_space_sel_n = ctl_r.io_sel_n;
	assign mem_strobe_n = ctl_r.mem_strobe_n;
	assign io_strobe_n = ctl_r.io_strobe_n;
	assign rw_n = ctl_r.rw;
	assign instr_fetch_addr_n = ctl_r.fetch_n;
	assign bus_release_ack_n = !hold_st;
	// With WAIT_STATES at least READY_MIN_WS, low from first wait state until the last one begins
	assign wait_states_done_n = !(ready_gate && (state_r == ST_WAIT) && !ws_last);

	// Assertions watch the pins as the far side sees them
	a_one_select: assert property (@(posedge core_clk) disable iff (rst)
		$countones({data_space_sel_n, program_space_sel_n, io_space_sel_n}) >= 2)
		else $error("more than one space select low");
	a_mem_strobe_space: assert property (@(posedge core_clk) disable iff (rst)
		!mem_strobe_n |-> io_space_sel_n && io_strobe_n)
		else $error("memory strobe during I/O cycle");
	a_io_strobe_space: assert property (@(posedge core_clk) disable iff (rst)
		!io_strobe_n |-> !io_space_sel_n && mem_strobe_n)
		else $error("I/O strobe without I/O select");
	a_rw_idle_high: assert property (@(posedge core_clk) disable iff (rst)
		!busy |-> rw_n)
		else $error("direction low outside a cycle");
	a_hold_float: assert property (@(posedge core_clk) disable iff (rst)
		!bus_release_ack_n |-> !ctl_oe && !addr_oe && !data_oe)
		else $error("bus driven while released");
	a_float_ctrl: assert property (@(posedge core_clk) disable iff (rst)
		!float_n_s |-> !ctl_oe && !addr_oe)
		else $error("outputs driven while float control low");
	a_hold_entry: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
		(state_r == ST_IDLE) && hold_s |=> !bus_release_ack_n)
		else $error("hold not acknowledged");
	sequence s_ready_wait;
		(state_r == ST_READY) && !ready_s && clk_en;
	endsequence
	a_ready_stall: assert property (@(posedge core_clk) disable iff (rst)
		s_ready_wait |=> busy && !rsp_valid)
		else $error("cycle ended while ready low");
	a_addr_upper: assert property (@(posedge core_clk) disable iff (rst)
		busy && cur_r.space != ext_bus_pkg::SPACE_PROG |->
		addr_o[ext_bus_pkg::ADDR_W-1:ext_bus_pkg::LOW_ADDR_W] == '0)
		else $error("upper address used outside program space");
	a_wait_done_start: assert property (@(posedge core_clk) disable iff (rst)
		ready_gate && ext_take && clk_en |=> !wait_states_done_n)
		else $error("wait-done output not low in first wait state");
	a_boot_addr: assert property (@(posedge core_clk) disable iff (rst)
		boot_pend_r && ext_take && clk_en |=> addr_o == ext_bus_pkg::RESET_FETCH_ADDR &&
		!instr_fetch_addr_n && !program_space_sel_n)
		else $error("first fetch not at reset address");
endmodule : ext_memory_bus_interface
`default_nettype wire

// ---- core/ext_bus_pkg.sv ----
/*
 * Shared constants and carrier types for the external memory bus interface.
 * Assumes a single core clock domain; pins are resolved to wires by the bench.
 */
`default_nettype none
package ext_bus_pkg;
	localparam int ADDR_W = 20;
	localparam int LOW_ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int WS_W = 3;
	localparam logic [ADDR_W-1:0] RESET_FETCH_ADDR = 20'h0FF80;
	localparam logic [LOW_ADDR_W-1:0] ROM_BASE = 16'hF000;
	localparam logic [WS_W-1:0] READY_MIN_WS = 3'h2;
	localparam logic [WS_W-1:0] WS_ONE = 3'h1;

	typedef enum logic [1:0] {
		SPACE_PROG = 2'b00,
		SPACE_DATA = 2'b01,
		SPACE_IO = 2'b10
	} space_t;

	typedef struct packed {
		space_t space;
		logic write;
		logic fetch;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic data_sel_n;
		logic prog_sel_n;
		logic io_sel_n;
		logic mem_strobe_n;
		logic io_strobe_n;
		logic rw;
		logic fetch_n;
	} bus_ctl_t;

	localparam bus_ctl_t CTL_IDLE = 7'h7F;
endpackage : ext_bus_pkg
`default_nettype wire

// ---- verification/ext_mem_model.sv ----
/*
 * Small external memory standing on the far side of the bus.
 * Assumes one core clock; resolves the shared data wire itself.
 */
`default_nettype none
module ext_mem_model (
	input wire logic core_clk,
	input wire logic [19:0] addr_o,
	input wire logic [15:0] data_o,
	input wire logic data_oe,
	input wire logic mem_strobe_n,
	input wire logic io_strobe_n,
	input wire logic rw_n,
	input wire logic [3:0] slow,
	output logic ready_pin,
	output logic [15:0] data_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [16];
	logic [15:0] last_r;
	logic [3:0] cnt_r;
	wire act = !(mem_strobe_n && io_strobe_n);
	// Only 16 words, so spaces alias on purpose
	assign ready_pin = !(act && cnt_r < slow);
	// Released bus shows a changing pattern, not the last value
	assign data_i = data_oe ? data_o : (act && rw_n) ? mem[addr_o[3:0]] : ~last_r;
	always @(posedge core_clk) begin
		last_r <= data_i;
		cnt_r <= act ? cnt_r + 4'h1 : 4'h0;
		if (act && !rw_n)
			mem[addr_o[3:0]] <= data_o;
	end
endmodule : ext_mem_model
`default_nettype wire

// ---- verification/tb_ext_memory_bus_interface.sv ----
/*
 * Self-checking bench for the external bus interface.
 * Assumes the memory model as the only party on the bus.
 */
`default_nettype none
module tb_ext_memory_bus_interface;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [2:0] WS = 3'h3;
	typedef struct packed {
		ext_bus_pkg::bus_req_t rq;
		ext_bus_pkg::bus_ctl_t ctl;
		logic [15:0] rd;
	} row_t;
	localparam row_t ROWS [5] = '{
		{ext_bus_pkg::SPACE_DATA, 2'b10, 20'h00003, 16'h1234, 7'h35, 16'h0000},
		{ext_bus_pkg::SPACE_IO, 2'b10, 20'h00005, 16'hA5C3, 7'h69, 16'h0000},
		{ext_bus_pkg::SPACE_DATA, 2'b00, 20'h00003, 16'h0000, 7'h37, 16'h1234},
		{ext_bus_pkg::SPACE_IO, 2'b00, 20'h00005, 16'h0000, 7'h6B, 16'hA5C3},
		{ext_bus_pkg::SPACE_PROG, 2'b01, 20'h10003, 16'h0000, 7'h56, 16'h1234}};
	logic core_clk, rst, rom_map_mode_sel, mode_override_valid, mode_override;
	logic req_valid, hold_req_n, emu_float_ctrl_n, rom, wsd_seen, clk_en;
	logic [3:0] slow;
	logic [15:0] rd;
	logic [19:0] a1;
	ext_bus_pkg::bus_req_t req;
	ext_bus_pkg::bus_ctl_t ctl1;
	wire req_ready, rsp_valid, rsp_internal_rom, processor_mode_status, ready_pin;
	wire addr_oe, data_oe, ctl_oe, bus_release_ack_n, wait_states_done_n;
	wire data_space_sel_n, program_space_sel_n, io_space_sel_n, mem_strobe_n;
	wire io_strobe_n, rw_n, instr_fetch_addr_n;
	wire [19:0] addr_o;
	wire [15:0] rsp_rdata, data_i, data_o;
	wire ext_bus_pkg::bus_ctl_t ctl = {data_space_sel_n, program_space_sel_n,
		io_space_sel_n, mem_strobe_n, io_strobe_n, rw_n, instr_fetch_addr_n};
	int fails = 0;
	int num_checks = 0;
	int lat;
	ext_memory_bus_interface #(.WAIT_STATES(WS)) u_dut (.core_clk, .rst, .clk_en,
		.rom_map_mode_sel, .mode_override_valid, .mode_override, .req_valid, .req_ready,
		.req, .rsp_valid, .rsp_rdata, .rsp_internal_rom, .processor_mode_status,
		.ready_pin, .hold_req_n, .emu_float_ctrl_n, .addr_o, .addr_oe, .data_i, .data_o,
		.data_oe, .data_space_sel_n, .program_space_sel_n, .io_space_sel_n, .mem_strobe_n,
		.io_strobe_n, .rw_n, .instr_fetch_addr_n, .bus_release_ack_n,
		.wait_states_done_n, .ctl_oe);
	ext_mem_model u_mem (.core_clk, .addr_o, .data_o, .data_oe, .mem_strobe_n,
		.io_strobe_n, .rw_n, .slow, .ready_pin, .data_i);
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic results;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	// Request held until the edge that takes it, then results gathered
	task automatic xfer(input ext_bus_pkg::bus_req_t r);
		req = r;
		req_valid = 1'b1;
		for (int k = 0; k < 50 && req_ready !== 1'b1; k++)
			@(negedge core_clk);
		check(req_ready, 1'b1);
		@(negedge core_clk);
		req_valid = 1'b0;
		ctl1 = ctl;
		a1 = addr_o;
		// Edges after the taking edge until the response stands
		lat = 0;
		wsd_seen = 1'b0;
		rom = 1'b0;
		while (rsp_valid !== 1'b1 && lat < 60) begin
			wsd_seen |= !wait_states_done_n;
			rom |= rsp_internal_rom;
			@(negedge core_clk);
			lat++;
		end
		check(rsp_valid, 1'b1);
		rom |= rsp_internal_rom;
		rd = rsp_rdata;
		check(ctl, ext_bus_pkg::CTL_IDLE);
		// Keeps the next request off the edge that lowered this one
		@(negedge core_clk);
	endtask : xfer
	task automatic do_reset(input logic sel);
		rst = 1'b1;
		rom_map_mode_sel = sel;
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask : do_reset
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#100000;
		fails++;
		results();
	end
	initial begin
		{req_valid, mode_override_valid, mode_override, slow, req} = '0;
		{hold_req_n, emu_float_ctrl_n, clk_en} = 3'h7;
		do_reset(1'b1);
		// A data write turned into the reset fetch
		xfer({ext_bus_pkg::SPACE_DATA, 2'b10, 20'h00007, 16'h0000});
		check(a1, 20'h0FF80);
		check(ctl1, 7'h56);
		foreach (ROWS[i]) begin
			xfer(ROWS[i].rq);
			check(ctl1, ROWS[i].ctl);
			check(a1, ROWS[i].rq.addr);
			check(20'(lat), 20'(WS + 1));
			check(wsd_seen, 1'b1);
			if (!ROWS[i].rq.write)
				check(rd, ROWS[i].rd);
		end
		slow = 4'h6;
		xfer(ROWS[2].rq);
		check(rd, 16'h1234);
		check(20'(lat > WS + 1), 20'h1);
		slow = 4'h0;
		hold_req_n = 1'b0;
		for (int k = 0; k < 10 && bus_release_ack_n !== 1'b0; k++)
			@(negedge core_clk);
		check(bus_release_ack_n, 1'b0);
		check({ctl_oe, addr_oe, data_oe, req_ready}, 4'h0);
		hold_req_n = 1'b1;
		emu_float_ctrl_n = 1'b0;
		repeat (3) @(negedge core_clk);
		check(ctl_oe, 1'b0);
		emu_float_ctrl_n = 1'b1;
		repeat (3) @(negedge core_clk);
		check({ctl_oe, bus_release_ack_n}, 2'h3);
		do_reset(1'b0);
		rom_map_mode_sel = 1'b1;
		xfer({ext_bus_pkg::SPACE_PROG, 2'b01, 20'h0F010, 16'h0000});
		check({rom, processor_mode_status}, 2'h2);
		xfer({ext_bus_pkg::SPACE_PROG, 2'b01, 20'h0F010, 16'h0000});
		check({rom, ctl1}, {1'b1, ext_bus_pkg::CTL_IDLE});
		{mode_override_valid, mode_override} = 2'b11;
		@(negedge core_clk);
		mode_override_valid = 1'b0;
		check(processor_mode_status, 1'b1);
		xfer({ext_bus_pkg::SPACE_PROG, 2'b01, 20'h0F010, 16'h0000});
		check({rom, ctl1}, 8'h56);
		// Clock enable low: a hold request must not get through
		clk_en = 1'b0;
		hold_req_n = 1'b0;
		repeat (5) @(negedge core_clk);
		check(bus_release_ack_n, 1'b1);
		hold_req_n = 1'b1;
		clk_en = 1'b1;
		results();
	end
endmodule : tb_ext_memory_bus_interface
`default_nettype wire
